// >>> design/acc_pkg.sv
// constants and state types of the converter control block
// assumes an 8-bit register view placed in the low byte of a 32-bit AXI4-Lite word
package acc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 12;
    localparam int DIV_W = 5;
    localparam int STEP_W = 4;
    localparam int NPINS = 4;
    localparam int CH_W = 2;
    localparam int CS_W = 3;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFF_CONV_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CONV_CLOCK = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RESULT_LOW = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_RESULT_HIGH = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CONTROL = 8'h10;

    // conv_control_reg fields
    localparam int POS_CHANNEL = 0;
    localparam int POS_PINS = 2;
    localparam int POS_BUSY = 6;
    localparam int POS_START = 7;
    // conv_clock_reg fields
    localparam int POS_CLK_SEL = 0;
    localparam int POS_POWER_DOWN = 6;
    localparam int POS_TEST = 7;
    // irq control fields
    localparam int POS_CONV_IRQ_EN = 0;
    localparam int POS_MF_IRQ_EN = 1;
    localparam int POS_GLOBAL_IRQ_EN = 2;
    localparam int POS_CONV_IRQ_FLAG = 4;

    // reset values
    localparam logic TEST_RST = 1'b1;
    localparam logic POWER_DOWN_RST = 1'b0;
    localparam logic BUSY_RST = 1'b0;
    localparam logic [CS_W-1:0] CLK_SEL_RST = 3'h0;

    // converter clock select encodings
    localparam logic [CS_W-1:0] CS_DIV2 = 3'h0;
    localparam logic [CS_W-1:0] CS_DIV8 = 3'h1;
    localparam logic [CS_W-1:0] CS_DIV32 = 3'h2;
    localparam logic [CS_W-1:0] CS_DIV1 = 3'h4;
    localparam logic [CS_W-1:0] CS_DIV4 = 3'h5;
    localparam logic [CS_W-1:0] CS_DIV16 = 3'h6;

    // conversion timing in converter clock periods
    localparam logic [STEP_W-1:0] SAMPLE_PERIODS = 4'h4;
    localparam logic [STEP_W-1:0] LAST_PERIOD = 4'hf;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_CONV
    } acc_conv_state_t;

    typedef struct packed {
        logic [CH_W-1:0] channel_select;
        logic [NPINS-1:0] analog_pin_config;
        logic start;
        logic conv_busy_n_done;
        logic [CS_W-1:0] conv_clock_select;
        logic conv_power_down;
        logic test;
        logic conv_irq_enable;
        logic multi_function_irq_enable;
        logic global_irq_enable;
        logic conv_irq_flag;
        logic [RES_W-1:0] result;
        logic [RES_W-1:0] sar;
        logic [STEP_W-1:0] step;
        logic [DIV_W-1:0] div_cnt;
        acc_conv_state_t state;
        logic [1:0] cmp_sync;
        logic ana_power_on;
        logic ana_reset;
        logic ana_sample;
        logic conv_irq;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_have;
        logic w_have;
        logic [ADDR_W-1:0] aw_addr;
        logic [7:0] w_byte;
        logic w_lane0;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } acc_state_t;
endpackage

// >>> design/acc_top.sv
// converter control: register file, clock divider, start sequencing, sar stepping
// assumes an analog front end that takes channel, pin, power, reset, sample and dac
// code, and returns one comparator level that is asynchronous to clk
`timescale 1ns/1ps
module acc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [acc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [acc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [acc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [acc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stack_full,
    input wire logic ana_cmp_in,
    output logic [acc_pkg::CH_W-1:0] ana_channel_select,
    output logic [acc_pkg::NPINS-1:0] ana_pin_analog,
    output logic ana_power_on,
    output logic ana_reset,
    output logic ana_sample,
    output logic [acc_pkg::RES_W-1:0] ana_dac_code,
    output logic conv_irq,
    output logic conv_busy_n_done
);

    acc_pkg::acc_state_t q;
    acc_pkg::acc_state_t d;

    // last divider count for a clock select code; top bit flags a usable code
    function automatic logic [acc_pkg::DIV_W:0] div_last(input logic [acc_pkg::CS_W-1:0] cs);
        logic [acc_pkg::DIV_W:0] r;
        r = '0;
        case (cs)
            acc_pkg::CS_DIV1: r = {1'b1, 5'h00};
            acc_pkg::CS_DIV2: r = {1'b1, 5'h01};
            acc_pkg::CS_DIV4: r = {1'b1, 5'h03};
            acc_pkg::CS_DIV8: r = {1'b1, 5'h07};
            acc_pkg::CS_DIV16: r = {1'b1, 5'h0f};
            acc_pkg::CS_DIV32: r = {1'b1, 5'h1f};
            default: r = '0;
        endcase
        return r;
    endfunction

    // register read mux; top bit flags a mapped address
    function automatic logic [acc_pkg::DATA_W:0] rd_mux(input logic [acc_pkg::ADDR_W-1:0] a,
                                                        input acc_pkg::acc_state_t s);
        logic [7:0] b;
        logic ok;
        b = '0;
        ok = 1'b1;
        case (a)
            acc_pkg::OFF_CONV_CONTROL: begin
                b[acc_pkg::POS_CHANNEL +: acc_pkg::CH_W] = s.channel_select;
                b[acc_pkg::POS_PINS +: acc_pkg::NPINS] = s.analog_pin_config;
                b[acc_pkg::POS_BUSY] = s.conv_busy_n_done;
                b[acc_pkg::POS_START] = s.start;
            end
            acc_pkg::OFF_CONV_CLOCK: begin
                b[acc_pkg::POS_CLK_SEL +: acc_pkg::CS_W] = s.conv_clock_select;
                b[acc_pkg::POS_POWER_DOWN] = s.conv_power_down;
                b[acc_pkg::POS_TEST] = s.test;
            end
            acc_pkg::OFF_RESULT_LOW: b = s.result[7:0];
            acc_pkg::OFF_RESULT_HIGH: b[3:0] = s.result[acc_pkg::RES_W-1:8];
            acc_pkg::OFF_IRQ_CONTROL: begin
                b[acc_pkg::POS_CONV_IRQ_EN] = s.conv_irq_enable;
                b[acc_pkg::POS_MF_IRQ_EN] = s.multi_function_irq_enable;
                b[acc_pkg::POS_GLOBAL_IRQ_EN] = s.global_irq_enable;
                b[acc_pkg::POS_CONV_IRQ_FLAG] = s.conv_irq_flag;
            end
            default: ok = 1'b0;
        endcase
        return {ok, 24'h000000, b};
    endfunction

    logic [acc_pkg::DIV_W:0] div_info;
    logic [acc_pkg::DATA_W:0] rd_word;
    logic do_write;
    logic tick;
    logic cmp_bit;
    logic [3:0] bit_idx;

    always_comb begin
        d = q;
        div_info = div_last(q.conv_clock_select);
        rd_word = rd_mux(s_axi_araddr, q);
        do_write = 1'b0;
        tick = 1'b0;
        cmp_bit = q.cmp_sync[1];
        bit_idx = '0;

        // comparator level through two flops
        d.cmp_sync = {q.cmp_sync[0], ana_cmp_in};

        // write address and data are taken in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.w_byte = s_axi_wdata[7:0];
            d.w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bready && q.bvalid) begin
            d.bvalid = 1'b0;
        end
        do_write = d.aw_have && d.w_have && !d.bvalid;
        if (do_write) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = acc_pkg::RESP_OKAY;
            case (d.aw_addr)
                acc_pkg::OFF_CONV_CONTROL: begin
                    if (d.w_lane0) begin
                        d.channel_select = d.w_byte[acc_pkg::POS_CHANNEL +: acc_pkg::CH_W];
                        d.analog_pin_config = d.w_byte[acc_pkg::POS_PINS +: acc_pkg::NPINS];
                        d.start = d.w_byte[acc_pkg::POS_START];
                    end
                end
                acc_pkg::OFF_CONV_CLOCK: begin
                    if (d.w_lane0) begin
                        d.conv_clock_select = d.w_byte[acc_pkg::POS_CLK_SEL +: acc_pkg::CS_W];
                        d.conv_power_down = d.w_byte[acc_pkg::POS_POWER_DOWN];
                        d.test = d.w_byte[acc_pkg::POS_TEST];
                    end
                end
                acc_pkg::OFF_RESULT_LOW, acc_pkg::OFF_RESULT_HIGH: begin
                    d.bresp = acc_pkg::RESP_OKAY;
                end
                acc_pkg::OFF_IRQ_CONTROL: begin
                    if (d.w_lane0) begin
                        d.conv_irq_enable = d.w_byte[acc_pkg::POS_CONV_IRQ_EN];
                        d.multi_function_irq_enable = d.w_byte[acc_pkg::POS_MF_IRQ_EN];
                        d.global_irq_enable = d.w_byte[acc_pkg::POS_GLOBAL_IRQ_EN];
                        d.conv_irq_flag = d.w_byte[acc_pkg::POS_CONV_IRQ_FLAG];
                    end
                end
                default: d.bresp = acc_pkg::RESP_SLVERR;
            endcase
        end
        d.awready = !d.aw_have;
        d.wready = !d.w_have;

        // reads answer one cycle after the address is taken
        if (s_axi_rready && q.rvalid) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rdata = rd_word[acc_pkg::DATA_W-1:0];
            d.rresp = rd_word[acc_pkg::DATA_W] ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
        end
        d.arready = !d.rvalid;

        // converter clock enable from the divider; unusable codes never tick
        tick = div_info[acc_pkg::DIV_W] && (q.div_cnt == div_info[acc_pkg::DIV_W-1:0]);
        if (q.state == acc_pkg::ST_CONV) begin
            d.div_cnt = tick ? '0 : q.div_cnt + 1'b1;
        end else begin
            d.div_cnt = '0;
        end

        // start sequencing and sar stepping; software writes above, hardware sets win
        case (q.state)
            acc_pkg::ST_IDLE: begin
                if (q.start) begin
                    d.state = acc_pkg::ST_ARMED;
                    d.conv_busy_n_done = 1'b1;
                end
            end
            acc_pkg::ST_ARMED: begin
                d.conv_busy_n_done = 1'b1;
                if (!q.start) begin
                    d.state = acc_pkg::ST_CONV;
                    d.step = '0;
                    d.sar = '0;
                end
            end
            acc_pkg::ST_CONV: begin
                if (q.start) begin
                    d.state = acc_pkg::ST_ARMED;
                end else if (tick) begin
                    d.step = q.step + 1'b1;
                    if (q.step == acc_pkg::SAMPLE_PERIODS - 1'b1) begin
                        d.sar[acc_pkg::RES_W-1] = 1'b1;
                    end else if (q.step >= acc_pkg::SAMPLE_PERIODS) begin
                        // decide the bit under trial, then trial the next lower one
                        bit_idx = 4'(acc_pkg::LAST_PERIOD - q.step);
                        d.sar[bit_idx] = cmp_bit;
                        if (bit_idx != '0) begin
                            d.sar[bit_idx - 1'b1] = 1'b1;
                        end
                    end
                    if (q.step == acc_pkg::LAST_PERIOD) begin
                        d.result = d.sar;
                        d.conv_busy_n_done = 1'b0;
                        d.conv_irq_flag = 1'b1;
                        d.state = acc_pkg::ST_IDLE;
                    end
                end
            end
            default: d.state = acc_pkg::ST_IDLE;
        endcase

        // power: off by control bit or with no analog pins selected
        d.ana_power_on = !d.conv_power_down && (|d.analog_pin_config);
        if (!d.ana_power_on && d.state == acc_pkg::ST_CONV) begin
            d.state = acc_pkg::ST_IDLE;
        end
        d.ana_reset = (d.state != acc_pkg::ST_CONV);
        d.ana_sample = (d.state == acc_pkg::ST_CONV) && (d.step < acc_pkg::SAMPLE_PERIODS);

        // interrupt request gated by all enables and stack room
        d.conv_irq = d.conv_irq_flag && d.conv_irq_enable && d.multi_function_irq_enable
                     && d.global_irq_enable && !stack_full;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.test <= acc_pkg::TEST_RST;
            q.conv_power_down <= acc_pkg::POWER_DOWN_RST;
            q.conv_busy_n_done <= acc_pkg::BUSY_RST;
            q.conv_clock_select <= acc_pkg::CLK_SEL_RST;
            q.state <= acc_pkg::ST_IDLE;
            q.ana_reset <= 1'b1;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // all outputs straight from the state flops
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;
    assign ana_channel_select = q.channel_select;
    assign ana_pin_analog = q.analog_pin_config;
    assign ana_power_on = q.ana_power_on;
    assign ana_reset = q.ana_reset;
    assign ana_sample = q.ana_sample;
    assign ana_dac_code = q.sar;
    assign conv_irq = q.conv_irq;
    assign conv_busy_n_done = q.conv_busy_n_done;

endmodule

// >>> testbench/acc_conv_monitor.sv
// assertion checker for the converter control block, bound to acc_top
// assumes every watched port belongs to the clk domain
`timescale 1ns/1ps
module acc_conv_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [acc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [acc_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stack_full,
    input wire logic [acc_pkg::NPINS-1:0] ana_pin_analog,
    input wire logic ana_power_on,
    input wire logic ana_reset,
    input wire logic ana_sample,
    input wire logic conv_irq,
    input wire logic conv_busy_n_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_done_then_reset: assert property ($fell(conv_busy_n_done) |-> ana_reset)
        else $error("busy fell while converter not back in reset");
    a_conv_keeps_busy: assert property (!ana_reset |-> conv_busy_n_done)
        else $error("converting with busy low");
    a_held_no_sample: assert property (ana_reset |-> !ana_sample)
        else $error("sampling while converter held in reset");
    a_start_samples: assert property ($fell(ana_reset) |-> ana_sample)
        else $error("conversion did not open with sampling");
    a_pins_off_power: assert property (ana_pin_analog == 4'h0 |-> !ana_power_on)
        else $error("converter powered with no analog pin");
    a_stack_masks_irq: assert property (stack_full |=> !conv_irq)
        else $error("interrupt raised while stack full");
    a_irq_after_done: assert property ($rose(conv_irq) |-> !conv_busy_n_done)
        else $error("interrupt rose during conversion");
    a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 8'h10 |=> s_axi_rvalid && s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");

    cover property ($fell(conv_busy_n_done));
    cover property ($rose(conv_irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind acc_top acc_conv_monitor u_acc_conv_monitor (.clk(clk), .rst_n(rst_n),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .stack_full(stack_full), .ana_pin_analog(ana_pin_analog),
    .ana_power_on(ana_power_on), .ana_reset(ana_reset), .ana_sample(ana_sample),
    .conv_irq(conv_irq), .conv_busy_n_done(conv_busy_n_done));

// >>> testbench/acc_top_tb.sv
// bench for the converter control block: register traffic and conversions
// assumes an ideal comparator, modelled here against a chosen input code
`timescale 1ns/1ps
module acc_top_tb;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, sf = 1'b0, cmp = 1'b0;
    logic awr, wr, bv, arr, rv, pon, ares, samp, irq, busy;
    logic [1:0] br, rr, ch;
    logic [3:0] pins;
    logic [11:0] dac, vin = 12'h0;
    logic [2:0] cs_tab [6] = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2};
    int n_tab [6] = '{1, 2, 4, 8, 16, 32};
    int mismatches = 0, checked = 0;

    always #20 clk = ~clk;
    // comparator: high when input is at or above the trial code
    always @(posedge clk) cmp <= (vin >= dac);

    acc_top u_acc_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .stack_full(sf),
        .ana_cmp_in(cmp), .ana_channel_select(ch), .ana_pin_analog(pins), .ana_power_on(pon),
        .ana_reset(ares), .ana_sample(samp), .ana_dac_code(dac), .conv_irq(irq),
        .conv_busy_n_done(busy));

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awr)
                ad = 1'b1;
            if (wr)
                dd = 1'b1;
            if (ad)
                awv <= 1'b0;
            if (dd)
                wv <= 1'b0;
        end
        do @(posedge clk); while (bv !== 1'b1);
        bre <= 1'b0;
        chk("bresp", 32'h0, {30'h0, br});
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        d = rd;
        r = rr;
        rre <= 1'b0;
    endtask

    task automatic run_conv(input logic [2:0] cs, input int n);
        logic [31:0] d;
        logic [1:0] r, c;
        logic [3:0] p;
        logic [2:0] en;
        int hi, lo;
        c = 2'($urandom);
        p = 4'($urandom_range(15, 1));
        en = (n == 16) ? 3'h7 : 3'($urandom);
        vin <= (n == 32) ? 12'hfff : (n == 16) ? 12'h000 : 12'($urandom);
        sf <= 1'($urandom);
        wr_reg(8'h04, {29'h0, cs});
        wr_reg(8'h10, {29'h0, en});
        wr_reg(8'h00, {24'h0, 2'b10, p, c});
        repeat (3) @(posedge clk);
        chk("busy_armed", 32'h1, {31'h0, busy});
        chk("reset_armed", 32'h1, {31'h0, ares});
        chk("channel", {30'h0, c}, {30'h0, ch});
        chk("pins", {28'h0, p}, {28'h0, pins});
        chk("power_on", 32'h1, {31'h0, pon});
        wr_reg(8'h00, {24'h0, 2'b00, p, c});
        hi = 0;
        lo = 0;
        do begin
            @(posedge clk);
            hi += int'(ares === 1'b0);
            lo += int'(samp === 1'b1);
        end while (busy !== 1'b0);
        chk("conv_cycles", 32'(16 * n), 32'(hi));
        chk("sample_cycles", 32'(4 * n), 32'(lo));
        rd_reg(8'h08, d, r);
        if (n >= 8)
            chk("result_low", {24'h0, vin[7:0]}, d);
        rd_reg(8'h0c, d, r);
        if (n >= 8)
            chk("result_high", {28'h0, vin[11:8]}, d);
        rd_reg(8'h10, d, r);
        chk("irq_flag", 32'h1, {31'h0, d[4]});
        rd_reg(8'h00, d, r);
        chk("busy_bit", 32'h0, {31'h0, d[6]});
        chk("conv_irq", {31'h0, &en & ~sf}, {31'h0, irq});
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(32'he33f));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h04, d, r);
        chk("clock_reg", 32'h80, d);
        rd_reg(8'h14, d, r);
        chk("unmapped_resp", 32'h2, {30'h0, r});
        for (int k = 0; k < 12; k++)
            run_conv(cs_tab[k % 6], n_tab[k % 6]);
        wr_reg(8'h04, 32'h40);
        repeat (3) @(posedge clk);
        chk("power_down", 32'h0, {31'h0, pon});
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h00, 32'h0);
        repeat (3) @(posedge clk);
        chk("pins_off_power", 32'h0, {31'h0, pon});
        chk("pins_off", 32'h0, {28'h0, pins});
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
